// ---- common/prog_port_pkg.sv ----
// Shared constants and types of the programming-port access layer.
// Assumes a byte-wide physical layer that reports frames on its own clock.
package prog_port_pkg;

  // ----------------------------------------------------------------
  // Opcodes and key
  // ----------------------------------------------------------------
  localparam logic [7:0]  OP_DLOAD     = 8'h20;
  localparam logic [7:0]  OP_DSTORE    = 8'h60;
  localparam logic [7:0]  OP_PTR       = 8'h68;
  localparam logic [7:0]  OP_KEY       = 8'he0;
  localparam int          OP_INC_BIT   = 2;
  localparam logic [63:0] ACT_KEY      = 64'h1289ab45cdd888ff;
  localparam int          KEY_BYTES    = 8;

  // ----------------------------------------------------------------
  // Control/status space
  // ----------------------------------------------------------------
  localparam logic [3:0]  CTL_STATUS   = 4'h0;
  localparam logic [3:0]  CTL_GUARD    = 4'h2;
  localparam logic [3:0]  CTL_IDENT    = 4'hf;
  localparam int          STAT_EN_BIT  = 1;
  localparam logic [2:0]  GUARD_RST    = 3'h0;

  // ----------------------------------------------------------------
  // Positions in the sampled link word
  // ----------------------------------------------------------------
  localparam int          B_DONE       = 0;
  localparam int          B_PAR        = 1;
  localparam int          B_STOP       = 2;
  localparam int          B_TXDONE     = 3;
  localparam int          B_COLL       = 4;
  localparam int          B_DATA       = 5;
  localparam int          LINK_W       = 13;

  typedef enum logic [3:0] {
    K_NONE, K_DLOAD, K_DSTORE, K_PTR, K_IOR, K_IOW, K_CSR, K_CSW, K_KEY
  } instr_t;

  typedef enum logic [2:0] {
    S_IDLE, S_OPND, S_KEY, S_MEM, S_TX, S_ERR
  } state_t;

endpackage

// ---- src/link_sampler.sv ----
// Samples the programmer's clock and the physical layer's signals.
// Assumes those signals change only on falling edges of the link clock.
`timescale 1ns/10ps
module link_sampler
#(
  parameter int W = 13
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         link_clk,
  input  wire logic [W-1:0] link_in,
  output logic              rise,
  output logic [W-1:0]      link_q
);

  logic [W-1:0] meta_q;
  logic [2:0]   clk_q;

  // Clock and data take the same two stages, so they stay aligned
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      link_q <= '0;
      clk_q  <= 3'h0;
    end
    else
    begin
      meta_q <= link_in;
      link_q <= meta_q;
      clk_q  <= {clk_q[1:0], link_clk};
    end
  end

  assign rise = clk_q[1] & ~clk_q[2];

endmodule

// ---- src/byte_fifo.sv ----
// Small flop-based FIFO with valid/ready on both sides and a flush.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/10ps
module byte_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  // Pointer wrap and the full test rely on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : g_bad_size
    $error("byte_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;

  assign out_valid = wr_q != rd_q;
  assign in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (in_valid && in_ready)
      mem_q[wr_q[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || flush)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
        wr_q <= wr_q + 1'b1;
      if (out_valid && out_ready)
        rd_q <= rd_q + 1'b1;
    end
  end

endmodule

// ---- src/prog_port_access_layer.sv ----
// Instruction interpreter of the two-wire programming port.
// Assumes a physical layer that shifts bits on serial_clock_line and
// a memory bus that answers each request with a one-cycle mem_ack.
// What this block does
// - Parity error, frame error or break while receiving is an exception
// - A collision while transmitting is an exception
// - Any exception aborts the current transfer and enters error state
// - Error state ignores everything until a break, then goes idle
// - Instructions are one byte; stores take one operand, reads take none
// - Key opcode 1110 0000 is followed by eight key bytes
// - Data load 0010 0x00 reads data space at pointer, bit 2 increments
// - Data store 0110 0x00 writes data space at pointer, bit 2 increments
// - Pointer store 0110 100a writes pointer byte a
// - I/O read 0aa1 aaaa returns I/O byte at 6-bit address
// - I/O write 1aa1 aaaa stores operand at 6-bit I/O address
// - Control load 1000 aaaa returns control byte at 4-bit address
// - Control store 1100 aaaa writes control byte at 4-bit address
// - Programming starts disabled; only the exact 64-bit key enables it
// - Writing zero to the enable flag disables programming
// - Read instructions are answered by the device sending one byte
// - An all-zero frame, stop bits included, is a break
`timescale 1ns/10ps
module prog_port_access_layer
#(
  parameter int         FIFO_DEPTH = 8,
  // Arbitrary identification value
  parameter logic [7:0] IDENT      = 8'h5a
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        serial_clock_line,
  input  wire logic        rx_done,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_parity_bit,
  input  wire logic        rx_stop_ok,
  input  wire logic        tx_done,
  input  wire logic        tx_collision,
  output logic             rx_ready,
  output logic             tx_mode,
  output logic [7:0]       tx_data,
  output logic [2:0]       guard_time,
  output logic             mem_req,
  output logic             mem_io,
  output logic             mem_we,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [7:0]  mem_rdata,
  output logic             prog_enable,
  output logic             in_error
);

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  // one-byte opcode classes
  function automatic prog_port_pkg::instr_t decode(input logic [7:0] b);
    decode = prog_port_pkg::K_NONE;
    if (b == prog_port_pkg::OP_KEY)
      decode = prog_port_pkg::K_KEY;
    else if ((b & 8'hfb) == prog_port_pkg::OP_DLOAD)
      decode = prog_port_pkg::K_DLOAD;
    else if ((b & 8'hfb) == prog_port_pkg::OP_DSTORE)
      decode = prog_port_pkg::K_DSTORE;
    else if ((b & 8'hfe) == prog_port_pkg::OP_PTR)
      decode = prog_port_pkg::K_PTR;
    else if (b[4])
      decode = b[7] ? prog_port_pkg::K_IOW : prog_port_pkg::K_IOR;
    else if (b[7:4] == 4'h8)
      decode = prog_port_pkg::K_CSR;
    else if (b[7:4] == 4'hc)
      decode = prog_port_pkg::K_CSW;
  endfunction

  function automatic logic [5:0] io_addr(input logic [7:0] b);
    io_addr = {b[6:5], b[3:0]};
  endfunction

  // ----------------------------------------------------------------
  // Link sampling and exceptions
  // ----------------------------------------------------------------
  logic                                s_rise;
  logic [prog_port_pkg::LINK_W-1:0]    s_bus;
  logic [7:0]                          s_data;
  logic                                fr;
  logic                                par_err;
  logic                                stop_err;
  logic                                brk;
  logic                                coll;
  logic                                txd;
  logic                                exc;
  prog_port_pkg::state_t               state_q;
  logic                                tx_mode_q;

  link_sampler #(.W(prog_port_pkg::LINK_W)) u_sampler
  (
    .clk      (clk),
    .rst_n    (rst_n),
    .link_clk (serial_clock_line),
    .link_in  ({rx_data, tx_collision, tx_done, rx_stop_ok,
                rx_parity_bit, rx_done}),
    .rise     (s_rise),
    .link_q   (s_bus)
  );

  assign s_data   = s_bus[prog_port_pkg::B_DATA +: 8];
  assign fr       = s_rise & s_bus[prog_port_pkg::B_DONE] & ~tx_mode_q;
  // Even parity over the data bits
  // receive-side error checks, transmit-side collision and done
  assign par_err  = fr & (^s_data ^ s_bus[prog_port_pkg::B_PAR]);
  assign stop_err = fr & ~s_bus[prog_port_pkg::B_STOP];
  assign brk      = stop_err & (s_data == 8'h00)
                  & ~s_bus[prog_port_pkg::B_PAR];
  assign coll     = s_rise & s_bus[prog_port_pkg::B_COLL] & tx_mode_q;
  assign txd      = s_rise & s_bus[prog_port_pkg::B_TXDONE] & tx_mode_q;
  assign exc      = par_err | stop_err | coll;

  // ----------------------------------------------------------------
  // Receive FIFO
  // ----------------------------------------------------------------
  logic       push;
  logic       pop;
  logic       f_valid;
  logic [7:0] f_data;

  // Exceptions bypass the FIFO so they are seen even when it is full
  assign push = fr & ~exc & (state_q != prog_port_pkg::S_ERR);
  assign pop  = f_valid & (state_q == prog_port_pkg::S_IDLE ||
                           state_q == prog_port_pkg::S_OPND ||
                           state_q == prog_port_pkg::S_KEY);

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (exc),
    .in_valid  (push),
    .in_ready  (rx_ready),
    .in_data   (s_data),
    .out_valid (f_valid),
    .out_ready (pop),
    .out_data  (f_data)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  prog_port_pkg::instr_t kind_q;
  prog_port_pkg::instr_t f_kind;
  logic [7:0]            op_q;
  logic [2:0]            key_idx_q;
  logic                  key_ok_q;
  logic                  key_hit;
  logic                  mem_done;
  logic                  prog_en_q;
  logic [2:0]            guard_q;
  logic [7:0]            ctl_rd;

  assign f_kind   = decode(f_data);
  assign mem_done = mem_req & mem_ack;
  // key bytes arrive least significant first
  assign key_hit  = f_data == prog_port_pkg::ACT_KEY[key_idx_q*8 +: 8];

  always_comb
  begin
    case (op_q[3:0])
      prog_port_pkg::CTL_STATUS:
        ctl_rd = 8'(prog_en_q) << prog_port_pkg::STAT_EN_BIT;
      prog_port_pkg::CTL_GUARD:  ctl_rd = {5'h00, guard_q};
      prog_port_pkg::CTL_IDENT:  ctl_rd = IDENT;
      default:                   ctl_rd = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_q <= prog_port_pkg::S_IDLE;
    else if (state_q == prog_port_pkg::S_ERR)
    begin
      // only a break leaves the error state
      if (brk)
        state_q <= prog_port_pkg::S_IDLE;
    end
    else if (exc)
      state_q <= prog_port_pkg::S_ERR;
    else
    begin
      case (state_q)
        prog_port_pkg::S_IDLE:
          if (pop)
          begin
            case (f_kind)
              prog_port_pkg::K_KEY:   state_q <= prog_port_pkg::S_KEY;
              prog_port_pkg::K_DLOAD,
              prog_port_pkg::K_IOR:   state_q <= prog_port_pkg::S_MEM;
              prog_port_pkg::K_CSR:   state_q <= prog_port_pkg::S_TX;
              prog_port_pkg::K_NONE:  state_q <= prog_port_pkg::S_IDLE;
              default:                state_q <= prog_port_pkg::S_OPND;
            endcase
          end
        prog_port_pkg::S_OPND:
          if (pop)
            state_q <= (kind_q == prog_port_pkg::K_DSTORE ||
                        kind_q == prog_port_pkg::K_IOW)
                     ? prog_port_pkg::S_MEM : prog_port_pkg::S_IDLE;
        prog_port_pkg::S_KEY:
          if (pop && key_idx_q == 3'(prog_port_pkg::KEY_BYTES - 1))
            state_q <= prog_port_pkg::S_IDLE;
        prog_port_pkg::S_MEM:
          if (mem_done)
            state_q <= mem_we ? prog_port_pkg::S_IDLE : prog_port_pkg::S_TX;
        prog_port_pkg::S_TX:
          if (txd)
            state_q <= prog_port_pkg::S_IDLE;
        default:
          state_q <= prog_port_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      kind_q <= prog_port_pkg::K_NONE;
      op_q   <= 8'h00;
    end
    else if (pop && state_q == prog_port_pkg::S_IDLE)
    begin
      kind_q <= f_kind;
      op_q   <= f_data;
    end
  end

  // ----------------------------------------------------------------
  // Pointer
  // ----------------------------------------------------------------
  logic [15:0] ptr_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ptr_q <= 16'h0000;
    else if (pop && state_q == prog_port_pkg::S_OPND &&
             kind_q == prog_port_pkg::K_PTR && !exc)
    begin
      // byte select by opcode bit 0
      if (op_q[0])
        ptr_q[15:8] <= f_data;
      else
        ptr_q[7:0] <= f_data;
    end
    else if (mem_done && !mem_io && op_q[prog_port_pkg::OP_INC_BIT])
      ptr_q <= ptr_q + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Memory and I/O bus
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n || exc)
      mem_req <= 1'b0;
    else if (mem_done)
      mem_req <= 1'b0;
    else if (pop && !mem_req &&
             ((state_q == prog_port_pkg::S_IDLE &&
               (f_kind == prog_port_pkg::K_DLOAD ||
                f_kind == prog_port_pkg::K_IOR)) ||
              (state_q == prog_port_pkg::S_OPND &&
               (kind_q == prog_port_pkg::K_DSTORE ||
                kind_q == prog_port_pkg::K_IOW))))
      mem_req <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mem_io    <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= 16'h0000;
      mem_wdata <= 8'h00;
    end
    else if (pop && !mem_req)
    begin
      if (state_q == prog_port_pkg::S_IDLE)
      begin
        mem_io   <= f_kind == prog_port_pkg::K_IOR;
        mem_we   <= 1'b0;
        mem_addr <= (f_kind == prog_port_pkg::K_IOR)
                  ? {10'h000, io_addr(f_data)} : ptr_q;
      end
      else if (state_q == prog_port_pkg::S_OPND)
      begin
        mem_io    <= kind_q == prog_port_pkg::K_IOW;
        mem_we    <= 1'b1;
        mem_addr  <= (kind_q == prog_port_pkg::K_IOW)
                   ? {10'h000, io_addr(op_q)} : ptr_q;
        mem_wdata <= f_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit side
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n || exc || txd)
      tx_mode_q <= 1'b0;
    else if ((mem_done && !mem_we) ||
             (pop && state_q == prog_port_pkg::S_IDLE &&
              f_kind == prog_port_pkg::K_CSR))
      tx_mode_q <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tx_data <= 8'h00;
    else if (mem_done && !mem_we)
      tx_data <= mem_rdata;
    // control space answer, one cycle after the opcode
    else if (state_q == prog_port_pkg::S_TX &&
             kind_q == prog_port_pkg::K_CSR)
      tx_data <= ctl_rd;
  end

  // ----------------------------------------------------------------
  // Key and control/status registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n || state_q != prog_port_pkg::S_KEY)
    begin
      key_idx_q <= 3'h0;
      key_ok_q  <= 1'b1;
    end
    else if (pop)
    begin
      key_idx_q <= key_idx_q + 3'h1;
      key_ok_q  <= key_ok_q & key_hit;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prog_en_q <= 1'b0;
    // enable only on a full exact key
    else if (pop && !exc && state_q == prog_port_pkg::S_KEY &&
             key_idx_q == 3'(prog_port_pkg::KEY_BYTES - 1))
      prog_en_q <= prog_en_q | (key_ok_q & key_hit);
    else if (pop && !exc && state_q == prog_port_pkg::S_OPND &&
             kind_q == prog_port_pkg::K_CSW &&
             op_q[3:0] == prog_port_pkg::CTL_STATUS &&
             !f_data[prog_port_pkg::STAT_EN_BIT])
      prog_en_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      guard_q <= prog_port_pkg::GUARD_RST;
    else if (pop && !exc && state_q == prog_port_pkg::S_OPND &&
             kind_q == prog_port_pkg::K_CSW &&
             op_q[3:0] == prog_port_pkg::CTL_GUARD)
      guard_q <= f_data[2:0];
  end

  assign tx_mode     = tx_mode_q;
  assign guard_time  = guard_q;
  assign prog_enable = prog_en_q;
  assign in_error    = state_q == prog_port_pkg::S_ERR;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // A break inside the error state is also an exception, but it exits
  err_entry_a: assert property (exc && !in_error |=> in_error)
    else $error("exception did not enter error state");
  err_hold_a: assert property (in_error && !brk |=> in_error)
    else $error("error state left without break");
  err_exit_a: assert property (in_error && brk |=>
      state_q == prog_port_pkg::S_IDLE)
    else $error("break did not return to idle");
  coll_stop_a: assert property (coll |=> in_error && !tx_mode_q)
    else $error("collision did not stop transmit");
  parity_exc_a: assert property (par_err |=> in_error && !mem_req)
    else $error("parity error not handled");
  key_only_a: assert property ($rose(prog_en_q) |->
      $past(state_q) == prog_port_pkg::S_KEY && $past(key_ok_q))
    else $error("programming enabled without key");
  en_clear_a: assert property (pop && !exc &&
      state_q == prog_port_pkg::S_OPND && kind_q == prog_port_pkg::K_CSW &&
      op_q[3:0] == 4'h0 && !f_data[1] |=> !prog_en_q)
    else $error("enable flag not cleared");
  ptr_inc_a: assert property (mem_done && !mem_io && op_q[2] |=>
      ptr_q == $past(ptr_q) + 16'h0001)
    else $error("pointer not incremented");
  io_addr_a: assert property (mem_req && mem_io |->
      mem_addr == {10'h000, op_q[6:5], op_q[3:0]})
    else $error("wrong I/O address");
  tx_read_a: assert property (mem_done && !mem_we && !exc |=>
      tx_mode_q && tx_data == $past(mem_rdata))
    else $error("read answer not sent");

  key_ok_c: cover property ($rose(prog_en_q));
  recover_c: cover property (in_error ##[1:200] state_q == prog_port_pkg::S_IDLE);
  io_read_c: cover property (mem_done && mem_io && !mem_we);

endmodule

// ---- tb/prog_port_programmer.sv ----
// Model of the external programmer and the physical layer below the
// access layer. Assumes the access layer samples these pins on its clock.
`timescale 1ns/10ps
module prog_port_programmer
(
  output logic       serial_clock_line,
  output logic       rx_done,
  output logic [7:0] rx_data,
  output logic       rx_parity_bit,
  output logic       rx_stop_ok,
  output logic       tx_done,
  output logic       tx_collision
);
  // ----------------------------------------------------------------
  // Link timing
  // ----------------------------------------------------------------
  // Clock stands low between frames; frame and reply drift the phase a little
  initial
  begin
    serial_clock_line = 1'b0;
    rx_done           = 1'b0;
    rx_data           = 8'h00;
    rx_parity_bit     = 1'b1;
    rx_stop_ok        = 1'b0;
    tx_done           = 1'b0;
    tx_collision      = 1'b0;
  end

  task automatic tick;
    #40 serial_clock_line = 1'b1;
    #40 serial_clock_line = 1'b0;
  endtask

  // whole byte frames
  // Released data shows its inverse so stale values never pass
  task automatic frame(input logic [7:0] d, input logic bad_par,
                       input logic bad_stop);
    #1.3;
    rx_data       = d;
    rx_parity_bit = ^d ^ bad_par;
    rx_stop_ok    = !bad_stop;
    rx_done       = 1'b1;
    tick;
    rx_done       = 1'b0;
    rx_data       = ~d;
    rx_parity_bit = ~rx_parity_bit;
  endtask

  task automatic reply(input logic coll);
    #1.3;
    tick;
    tick;
    tx_done      = !coll;
    tx_collision = coll;
    tick;
    tx_done      = 1'b0;
    tx_collision = 1'b0;
  endtask

  task automatic send_key(input logic [63:0] k);
    frame(prog_port_pkg::OP_KEY, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++)
      frame(k[8*i +: 8], 1'b0, 1'b0);
  endtask

  task automatic resync;
    frame(8'h00, 1'b0, 1'b1);
    frame(8'h00, 1'b0, 1'b1);
  endtask
endmodule

// ---- tb/prog_port_access_layer_tb.sv ----
// Self-checking bench of the programming-port access layer.
// Assumes the programmer model and a one-cycle memory responder here.
`timescale 1ns/10ps
module prog_port_access_layer_tb;
  // Row: opcode, operand, flags {rd,mem,io,we}, address, value
  typedef logic [43:0] row_t;
  localparam row_t ROWS [16] = '{
    44'h68_34_0_0000_00, 44'h69_12_0_0000_00, 44'h60_a5_5_1234_a5,
    44'h64_5a_5_1234_5a, 44'h20_00_c_1235_75, 44'h24_00_c_1235_75,
    44'h20_00_c_1236_76, 44'h75_00_e_0035_75, 44'h10_00_e_0000_40,
    44'h9a_c3_7_000a_c3, 44'hff_3c_7_003f_3c, 44'hc2_05_0_0000_00,
    44'h82_00_8_0000_05, 44'h83_00_8_0000_00, 44'h8f_00_8_0000_a7,
    44'h80_00_8_0000_00};
  // Arbitrary identification value
  localparam logic [7:0] ID = 8'ha7;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hold = 1'b0;
  logic        mem_ack = 1'b0;
  logic [7:0]  mem_rdata = 8'h00;
  logic        serial_clock_line, rx_done, rx_parity_bit, rx_stop_ok;
  logic        tx_done, tx_collision, rx_ready, tx_mode, mem_req, mem_io;
  logic        mem_we, prog_enable, in_error, l_io, l_we;
  logic [7:0]  rx_data, tx_data, mem_wdata, got, l_wdata;
  logic [2:0]  guard_time;
  logic [15:0] mem_addr, l_addr;
  logic [3:0]  f;
  int          num_errors = 0;
  int          checks_done = 0;
  int          mem_cnt = 0;
  int          cnt0;

  always #2.5 clk = ~clk;

  prog_port_access_layer #(.FIFO_DEPTH(8), .IDENT(ID)) dut
  (
    .clk, .rst_n, .serial_clock_line, .rx_done, .rx_data, .rx_parity_bit,
    .rx_stop_ok, .tx_done, .tx_collision, .rx_ready, .tx_mode, .tx_data,
    .guard_time, .mem_req, .mem_io, .mem_we, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata, .prog_enable, .in_error
  );

  prog_port_programmer prg
  (
    .serial_clock_line, .rx_done, .rx_data, .rx_parity_bit, .rx_stop_ok,
    .tx_done, .tx_collision
  );

  // ----------------------------------------------------------------
  // Memory responder; hold stalls it so the FIFO backs up
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    mem_ack   <= mem_req && !mem_ack && !hold;
    mem_rdata <= (mem_req && !mem_ack) ? {2'b01, mem_addr[5:0]} : ~mem_rdata;
    if (mem_req && mem_ack)
    begin
      mem_cnt <= mem_cnt + 1;
      l_io    <= mem_io;
      l_we    <= mem_we;
      l_addr  <= mem_addr;
      l_wdata <= mem_wdata;
    end
  end

  task automatic check(input string nm, input logic [23:0] exp,
                       input logic [23:0] seen);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic xfer(input logic [7:0] op, input logic [7:0] opd,
                      input logic rd, input logic coll);
    prg.frame(op, 1'b0, 1'b0);
    if (!rd)
      prg.frame(opd, 1'b0, 1'b0);
    else
    begin
      for (int n = 0; n < 100 && tx_mode !== 1'b1; n++)
        @(posedge clk);
      repeat (2) @(posedge clk);
      got = tx_data;
      prg.reply(coll);
    end
    repeat (12) @(posedge clk);
  endtask

  task automatic complete_run;
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #400000;
    num_errors++;
    complete_run;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    check("reset", 24'h1, 24'({tx_mode, mem_req, prog_enable, in_error,
          guard_time, rx_ready}));
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (ROWS[i])
    begin
      f    = ROWS[i][27:24];
      cnt0 = mem_cnt;
      xfer(ROWS[i][43:36], ROWS[i][35:28], f[3], 1'b0);
      check("mem count", 24'(f[2]), 24'(mem_cnt - cnt0));
      check("tx mode", 24'h0, 24'(tx_mode));
      if (f[2])
        check("access", 24'({f[1:0], ROWS[i][23:8] & (f[1] ? 16'h3f : 16'hffff)}),
              24'({l_io, l_we, l_addr & (f[1] ? 16'h3f : 16'hffff)}));
      if (f[0])
        check("wdata", 24'(ROWS[i][7:0]), 24'(l_wdata));
      if (f[3])
        check("tx data", 24'(ROWS[i][7:0]), 24'(got));
    end
    check("guard", 24'h5, 24'(guard_time));
    prg.send_key(prog_port_pkg::ACT_KEY ^ 64'hff00_0000_0000_0000);
    repeat (12) @(posedge clk);
    check("bad key", 24'h0, 24'(prog_enable));
    prg.send_key(prog_port_pkg::ACT_KEY);
    repeat (12) @(posedge clk);
    check("key", 24'h1, 24'(prog_enable));
    xfer(8'h80, 8'h00, 1'b1, 1'b0);
    check("poll", 24'(1 << prog_port_pkg::STAT_EN_BIT), 24'(got));
    xfer(8'hc0, 8'h00, 1'b0, 1'b0);
    check("disable", 24'h0, 24'(prog_enable));
    cnt0 = mem_cnt;
    prg.frame(8'h60, 1'b0, 1'b0);
    prg.frame(8'ha5, 1'b1, 1'b0);
    xfer(8'h8f, 8'h00, 1'b0, 1'b0);
    check("parity", 24'h200, 24'({in_error, tx_mode, 8'(mem_cnt - cnt0)}));
    xfer(8'h00, 8'h00, 1'b1, 1'b0);
    check("silent", 24'h2, 24'({in_error, tx_mode}));
    prg.frame(8'h00, 1'b0, 1'b1);
    repeat (12) @(posedge clk);
    check("break exit", 24'h0, 24'(in_error));
    prg.frame(8'h60, 1'b0, 1'b0);
    prg.frame(8'ha5, 1'b0, 1'b1);
    repeat (12) @(posedge clk);
    check("frame err", 24'h1, 24'(in_error));
    prg.frame(8'h00, 1'b0, 1'b1);
    prg.frame(8'h60, 1'b0, 1'b0);
    prg.resync;
    xfer(8'h8f, 8'h00, 1'b1, 1'b0);
    check("resync", 24'(ID), 24'(got));
    xfer(8'h8f, 8'h00, 1'b1, 1'b1);
    check("collision", 24'h2, 24'({in_error, tx_mode}));
    prg.frame(8'h00, 1'b0, 1'b1);
    hold <= 1'b1;
    cnt0 = mem_cnt;
    for (int i = 0; i < 5; i++)
    begin
      prg.frame(8'h60, 1'b0, 1'b0);
      prg.frame(8'(i), 1'b0, 1'b0);
    end
    repeat (4) @(posedge clk);
    check("fifo full", 24'h0, 24'(rx_ready));
    hold <= 1'b0;
    repeat (100) @(posedge clk);
    check("drain", 24'h105, 24'({rx_ready, 8'(mem_cnt - cnt0)}));
    check("last store", 24'h4, 24'(l_wdata));
    complete_run;
  end
endmodule
